/* File: src/ssr_pkg.sv */
// Constants, types and helpers shared by the sync reference selector
// Function
// - Two clock modes: master from internal clock, automatic from an external reference.
// - Automatic selection considers only word clock, optical multichannel and SPDIF inputs.
// - In automatic mode a valid preferred input is always used as sync reference.
// - Without a valid preferred input, the first valid input becomes reference.
// - Automatic mode watches all inputs, switches to a valid one, reports slave.
// - Reference failure or no valid input falls back to internal clock, master.
// - A system clock state output shows master or slave.
// - Report the active reference input and its measured sample period.
// - Each input reports no lock, lock, or sync with the system clock.
// - Lock to any reference rate from 28 kHz to 200 kHz.
// - Word clock out follows the rate; single speed clamps it into 28-56 kHz.
// - Optical preferred at double speed enters sample multiplex mode, link at half rate.
// - Synthesis settings act only in master mode and only under the global enable.
// - Synthesized rate is base frequency times speed multiplier plus active fader offsets.
// - Coarse offset applies only while its active flag is set, 1 Hz steps.
// - Fine offset applies only while its active flag is set, 1 Hz steps.
// - Store writes all settings to nonvolatile memory; they load after power-on.
// - Recall replaces all active settings with the nonvolatile copy.
package ssr_pkg;

    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned MIN_REF_HZ   = 28_000;
    localparam int unsigned MAX_REF_HZ   = 200_000;
    localparam int unsigned DBL_MIN_HZ   = 56_000;
    localparam int unsigned QUAD_MIN_HZ  = 112_000;
    localparam int unsigned STD_RATE_HZ  = 48_000;

    localparam int unsigned PER_W        = 16;
    // Longest and shortest legal reference periods in clk cycles
    localparam logic [15:0] MAX_PER      = 16'(CLK_HZ / MIN_REF_HZ);
    localparam logic [15:0] MIN_PER      = 16'(CLK_HZ / MAX_REF_HZ);
    localparam logic [15:0] DBL_PER      = 16'(CLK_HZ / DBL_MIN_HZ);
    localparam logic [15:0] QUAD_PER     = 16'(CLK_HZ / QUAD_MIN_HZ);
    localparam logic [15:0] PER_SAT      = 16'hffff;

    localparam logic [15:0] LOCK_TOL     = 16'h0004;
    localparam logic [15:0] SYNC_TOL     = 16'h0004;
    localparam logic [2:0]  LOCK_GOOD    = 3'h4;
    localparam logic [1:0]  LOCK_BAD     = 2'h2;

    localparam int unsigned NUM_IN       = 3;
    localparam logic [1:0]  SPEED_SINGLE = 2'h0;
    localparam logic [1:0]  SPEED_DOUBLE = 2'h1;
    localparam logic [1:0]  SPEED_QUAD   = 2'h2;

    localparam logic [26:0] ACC_MOD      = 27'(CLK_HZ);

    typedef enum logic [1:0] {
        REF_WC    = 2'b00,
        REF_OPT   = 2'b01,
        REF_SPDIF = 2'b10,
        REF_NONE  = 2'b11
    } ssr_ref_t;

    typedef enum logic {
        CS_MASTER = 1'b0,
        CS_SLAVE  = 1'b1
    } ssr_clk_state_t;

    typedef enum logic [1:0] {
        LS_NO_LOCK = 2'b00,
        LS_LOCK    = 2'b01,
        LS_SYNC    = 2'b10
    } ssr_lock_t;

    typedef struct packed {
        logic             auto_mode;
        ssr_ref_t         pref;
        logic             single_speed;
        logic             synth_en;
        logic [17:0]      base_hz;
        logic [1:0]       mult;
        logic             coarse_act;
        logic signed [12:0] coarse_hz;
        logic             fine_act;
        logic signed [7:0]  fine_hz;
    } ssr_cfg_t;

    function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction : absdiff

endpackage : ssr_pkg

/* File: src/ssr_det_if.sv */
// Lock detector results carried from one input detector to the selector
`timescale 1ns/1ps
interface ssr_det_if;
    logic [15:0] period;
    logic        locked;
    logic        rise;
    logic        edge_seen;

    modport det (output period, output locked, output rise, output edge_seen);
    modport sel (input period, input locked, input rise, input edge_seen);
endinterface : ssr_det_if

/* File: src/ssr_lock_det.sv */
// Per-input clock synchroniser, period meter and filtered lock detector
`timescale 1ns/1ps
module ssr_lock_det (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Reference pin
    input  wire logic pin,
    // Results
    ssr_det_if.det    det
);
    logic        s1_q, s2_q, s3_q, lvl_q;
    logic [15:0] per_cnt_q, period_q, meas;
    logic [2:0]  good_q;
    logic [1:0]  bad_q;
    logic        locked_q, rise_q, edge_q;
    logic        chg, rise, in_range, good, timeout;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change counts only once stages two and three agree
    assign chg      = (s2_q == s3_q) && (s3_q != lvl_q);
    assign rise     = chg && s3_q;
    assign meas     = per_cnt_q + 16'h0001;
    assign in_range = (meas >= ssr_pkg::MIN_PER) && (meas <= ssr_pkg::MAX_PER);
    assign good     = in_range && (ssr_pkg::absdiff(meas, period_q) <= ssr_pkg::LOCK_TOL);
    assign timeout  = per_cnt_q > ssr_pkg::MAX_PER;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lvl_q  <= 1'b0;
            rise_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            if (chg) lvl_q <= s3_q;
            rise_q <= rise;
            edge_q <= chg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            per_cnt_q <= 16'h0000;
            period_q  <= 16'h0000;
        end else if (rise) begin
            per_cnt_q <= 16'h0000;
            // One stray period while locked must not replace the trusted period
            if (!locked_q || good) period_q <= meas;
        end else if (per_cnt_q != ssr_pkg::PER_SAT) begin
            per_cnt_q <= meas;
        end
    end

    // Several matching periods to gain lock, repeated misses to lose it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            good_q   <= 3'h0;
            bad_q    <= 2'h0;
            locked_q <= 1'b0;
        end else if (timeout) begin
            good_q   <= 3'h0;
            bad_q    <= 2'h0;
            locked_q <= 1'b0;
        end else if (rise && good) begin
            bad_q <= 2'h0;
            if (good_q != ssr_pkg::LOCK_GOOD) good_q <= good_q + 3'h1;
            else locked_q <= 1'b1;
        end else if (rise) begin
            good_q <= 3'h0;
            if (bad_q + 2'h1 == ssr_pkg::LOCK_BAD) begin
                bad_q    <= 2'h0;
                locked_q <= 1'b0;
            end else begin
                bad_q <= bad_q + 2'h1;
            end
        end
    end

    assign det.period    = period_q;
    assign det.locked    = locked_q;
    assign det.rise      = rise_q;
    assign det.edge_seen = edge_q;

endmodule : ssr_lock_det

/* File: src/ssr_top.sv */
// Sync reference selector: lock monitors, reference choice, synthesizer, word clock out
`timescale 1ns/1ps
module ssr_top (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Reference pins
    input  wire logic             wc_in,
    input  wire logic             opt_in,
    input  wire logic             spdif_in,
    // Settings and commands
    input  wire ssr_pkg::ssr_cfg_t cfg_in,
    input  wire logic             cfg_load,
    input  wire logic             store_cmd,
    input  wire logic             recall_cmd,
    // Nonvolatile settings store
    input  wire ssr_pkg::ssr_cfg_t nv_rdata,
    output logic                  nv_wr_q,
    output ssr_pkg::ssr_cfg_t     nv_wdata_q,
    // Status
    output ssr_pkg::ssr_cfg_t     cfg_q,
    output ssr_pkg::ssr_clk_state_t clock_state_q,
    output ssr_pkg::ssr_ref_t     active_reference_report_q,
    output logic [15:0]           ref_period_q,
    output logic [5:0]            per_input_lock_state_q,
    output logic                  sample_multiplex_mode_q,
    output logic [19:0]           sys_rate_hz_q,
    // Word clock output
    output logic                  wc_out_q
);
    logic [2:0]        pins;
    logic [2:0]        valid, rise_v, edge_v, sync_v;
    logic [15:0]       per_v [3];
    ssr_pkg::ssr_ref_t sel;
    logic              boot_q;
    logic [19:0]       synth_rate;
    logic [26:0]       acc_q, acc_sum;
    logic [20:0]       step;
    logic              tick, mlev_q;
    logic [15:0]       sys_cnt_q, sys_per_q;
    logic              sys_rise, wc_ev;
    logic [1:0]        speed, div;
    logic [1:0]        div_cnt_q;
    logic              ref_rise, ref_edge;
    logic [15:0]       ref_per;

    assign pins = {spdif_in, opt_in, wc_in};

    ssr_det_if det_if [ssr_pkg::NUM_IN] ();

    // One monitor per candidate input, in priority order
    for (genvar i = 0; i < ssr_pkg::NUM_IN; i++) begin : g_in
        ssr_lock_det u_det (
            .clk    (clk),
            .resetn (resetn),
            .pin    (pins[i]),
            .det    (det_if[i])
        );
        assign valid[i]  = det_if[i].locked;
        assign rise_v[i] = det_if[i].rise;
        assign edge_v[i] = det_if[i].edge_seen;
        assign per_v[i]  = det_if[i].period;
        assign sync_v[i] = det_if[i].locked
                           && (ssr_pkg::absdiff(det_if[i].period, sys_per_q)
                               <= ssr_pkg::SYNC_TOL);

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                per_input_lock_state_q[2*i +: 2] <= ssr_pkg::LS_NO_LOCK;
            end else if (sync_v[i]) begin
                per_input_lock_state_q[2*i +: 2] <= ssr_pkg::LS_SYNC;
            end else if (valid[i]) begin
                per_input_lock_state_q[2*i +: 2] <= ssr_pkg::LS_LOCK;
            end else begin
                per_input_lock_state_q[2*i +: 2] <= ssr_pkg::LS_NO_LOCK;
            end
        end
    end

    // Settings: power-on load from the store, then recall, then live writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_q <= 1'b1;
            cfg_q  <= '0;
        end else begin
            boot_q <= 1'b0;
            if (boot_q) begin
                cfg_q <= nv_rdata;
            end else if (recall_cmd) begin
                cfg_q <= nv_rdata;
            end else if (cfg_load) begin
                cfg_q <= cfg_in;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nv_wr_q    <= 1'b0;
            nv_wdata_q <= '0;
        end else begin
            nv_wr_q <= store_cmd && !boot_q;
            if (store_cmd) nv_wdata_q <= cfg_q;
        end
    end

    // Reference choice; only the three documented inputs are candidates
    always_comb begin
        sel = ssr_pkg::REF_NONE;
        if (cfg_q.auto_mode) begin
            if (cfg_q.pref != ssr_pkg::REF_NONE && valid[cfg_q.pref]) begin
                sel = cfg_q.pref;
            end else if (valid[0]) begin
                sel = ssr_pkg::REF_WC;
            end else if (valid[1]) begin
                sel = ssr_pkg::REF_OPT;
            end else if (valid[2]) begin
                sel = ssr_pkg::REF_SPDIF;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_reference_report_q <= ssr_pkg::REF_NONE;
            clock_state_q             <= ssr_pkg::CS_MASTER;
        end else begin
            active_reference_report_q <= sel;
            // No valid input or failed reference drops back to master
            clock_state_q <= (sel == ssr_pkg::REF_NONE) ? ssr_pkg::CS_MASTER
                                                       : ssr_pkg::CS_SLAVE;
        end
    end

    assign ref_rise = (active_reference_report_q != ssr_pkg::REF_NONE)
                      && rise_v[active_reference_report_q];
    assign ref_edge = (active_reference_report_q != ssr_pkg::REF_NONE)
                      && edge_v[active_reference_report_q];
    assign ref_per  = (active_reference_report_q != ssr_pkg::REF_NONE)
                      ? per_v[active_reference_report_q] : sys_per_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_period_q <= 16'h0000;
        end else begin
            ref_period_q <= ref_per;
        end
    end

    // Synthesized rate: base times speed plus whichever faders are active
    always_comb begin
        synth_rate = 20'(cfg_q.base_hz) << cfg_q.mult;
        if (cfg_q.coarse_act) begin
            synth_rate = synth_rate + 20'(cfg_q.coarse_hz);
        end
        if (cfg_q.fine_act) begin
            synth_rate = synth_rate + 20'(cfg_q.fine_hz);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sys_rate_hz_q <= 20'(ssr_pkg::STD_RATE_HZ);
        end else begin
            // Settings ignored unless master and globally enabled
            sys_rate_hz_q <= (cfg_q.synth_en && clock_state_q == ssr_pkg::CS_MASTER)
                             ? synth_rate : 20'(ssr_pkg::STD_RATE_HZ);
        end
    end

    // Phase accumulator at twice the rate; each tick flips the internal clock
    assign step    = {sys_rate_hz_q, 1'b0};
    assign acc_sum = acc_q + 27'(step);
    assign tick    = acc_sum >= ssr_pkg::ACC_MOD;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q  <= 27'h0000000;
            mlev_q <= 1'b0;
        end else begin
            acc_q <= tick ? acc_sum - ssr_pkg::ACC_MOD : acc_sum;
            if (tick) mlev_q <= !mlev_q;
        end
    end

    // System period: internal clock in master, recovered clock in slave
    assign sys_rise = (clock_state_q == ssr_pkg::CS_MASTER) ? (tick && !mlev_q) : ref_rise;
    assign wc_ev    = (clock_state_q == ssr_pkg::CS_MASTER) ? tick : ref_edge;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sys_cnt_q <= 16'h0000;
            sys_per_q <= 16'h0000;
        end else if (sys_rise) begin
            sys_cnt_q <= 16'h0000;
            sys_per_q <= sys_cnt_q + 16'h0001;
        end else if (sys_cnt_q != ssr_pkg::PER_SAT) begin
            sys_cnt_q <= sys_cnt_q + 16'h0001;
        end
    end

    // Speed class from the running period; zero means not yet measured
    always_comb begin
        if (sys_per_q != 16'h0000 && sys_per_q < ssr_pkg::QUAD_PER) begin
            speed = ssr_pkg::SPEED_QUAD;
        end else if (sys_per_q != 16'h0000 && sys_per_q < ssr_pkg::DBL_PER) begin
            speed = ssr_pkg::SPEED_DOUBLE;
        end else begin
            speed = ssr_pkg::SPEED_SINGLE;
        end
    end

    assign div = cfg_q.single_speed ? speed : ssr_pkg::SPEED_SINGLE;

    // Dividing the toggle events keeps the clamped output phase-tied to the rate
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q <= 2'h0;
            wc_out_q  <= 1'b0;
        end else if (wc_ev) begin
            if (div_cnt_q == 2'((3'h1 << div) - 3'h1)) begin
                div_cnt_q <= 2'h0;
                wc_out_q  <= !wc_out_q;
            end else begin
                div_cnt_q <= div_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_multiplex_mode_q <= 1'b0;
        end else begin
            // Optical link carries half the system rate in this mode
            sample_multiplex_mode_q <= cfg_q.auto_mode && cfg_q.pref == ssr_pkg::REF_OPT
                                       && speed == ssr_pkg::SPEED_DOUBLE;
        end
    end

endmodule : ssr_top

/* File: bench/ssr_ref_src.sv */
// Behavioural reference clock source standing in for outside equipment
`timescale 1ns/1ps
module ssr_ref_src (
    // Control from the bench
    input  wire logic        en,
    input  wire logic [15:0] half_ns,
    input  wire logic        skip,
    // Reference pin
    output logic             line
);
    // Free-running clock from its own timebase, never fed back from device outputs
    initial begin
        line = 1'b0;
        forever begin
            wait (en);
            #(half_ns) line = !skip;
            #(half_ns) line = 1'b0;
        end
    end
endmodule : ssr_ref_src

/* File: bench/ssr_top_sva.sv */
// Port-level assertions for the sync reference selector
`timescale 1ns/1ps
module ssr_top_sva (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    resetn,
    // Settings and commands
    input wire ssr_pkg::ssr_cfg_t       cfg_in,
    input wire logic                    cfg_load,
    input wire logic                    store_cmd,
    input wire logic                    recall_cmd,
    input wire ssr_pkg::ssr_cfg_t       nv_rdata,
    // Watched outputs
    input wire logic                    nv_wr_q,
    input wire ssr_pkg::ssr_cfg_t       nv_wdata_q,
    input wire ssr_pkg::ssr_cfg_t       cfg_q,
    input wire ssr_pkg::ssr_clk_state_t clock_state_q,
    input wire ssr_pkg::ssr_ref_t       active_reference_report_q,
    input wire logic [5:0]              per_input_lock_state_q,
    input wire logic                    sample_multiplex_mode_q,
    input wire logic [19:0]             sys_rate_hz_q
);
    logic               up_q;
    logic signed [21:0] exp_rate;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Boot cycle belongs to the power-on load, commands there are ignored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            up_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
        end
    end

    always_comb begin
        exp_rate = 22'(cfg_q.base_hz) << cfg_q.mult;
        if (cfg_q.coarse_act) begin
            exp_rate = exp_rate + 22'(cfg_q.coarse_hz);
        end
        if (cfg_q.fine_act) begin
            exp_rate = exp_rate + 22'(cfg_q.fine_hz);
        end
    end

    property p_store;
        store_cmd && up_q |=> nv_wr_q && nv_wdata_q == $past(cfg_q);
    endproperty
    a_store: assert property (p_store) else $error("store strobe or data wrong");
    property p_no_write;
        !store_cmd || !up_q |=> !nv_wr_q;
    endproperty
    a_no_write: assert property (p_no_write) else $error("stray memory write");
    property p_recall;
        recall_cmd && up_q |=> cfg_q == $past(nv_rdata);
    endproperty
    a_recall: assert property (p_recall) else $error("recall did not restore settings");
    property p_load;
        cfg_load && !recall_cmd && up_q |=> cfg_q == $past(cfg_in);
    endproperty
    a_load: assert property (p_load) else $error("settings load lost");
    property p_state;
        (clock_state_q == ssr_pkg::CS_SLAVE) == (active_reference_report_q != ssr_pkg::REF_NONE)
            && (active_reference_report_q == ssr_pkg::REF_NONE
                || per_input_lock_state_q[2*active_reference_report_q +: 2] != 2'h0);
    endproperty
    a_state: assert property (p_state) else $error("clock state disagrees with reference");
    property p_gate;
        (clock_state_q == ssr_pkg::CS_SLAVE || !cfg_q.synth_en) [*3] |-> sys_rate_hz_q == 20'hbb80;
    endproperty
    a_gate: assert property (p_gate) else $error("synth settings leaked");
    property p_rate;
        (clock_state_q == ssr_pkg::CS_MASTER && cfg_q.synth_en && $stable(cfg_q)) [*3]
            |-> sys_rate_hz_q == exp_rate[19:0];
    endproperty
    a_rate: assert property (p_rate) else $error("synth rate wrong");
    property p_code;
        per_input_lock_state_q[1:0] != 2'h3 && per_input_lock_state_q[3:2] != 2'h3
            && per_input_lock_state_q[5:4] != 2'h3;
    endproperty
    a_code: assert property (p_code) else $error("bad lock state code");
    property p_smux;
        (!cfg_q.auto_mode || cfg_q.pref != ssr_pkg::REF_OPT) [*2] |-> !sample_multiplex_mode_q;
    endproperty
    a_smux: assert property (p_smux) else $error("multiplex mode without optical pref");
endmodule : ssr_top_sva

/* File: bench/ssr_top_test.sv */
// Self-checking bench for the sync reference selector
`timescale 1ns/1ps
module ssr_top_test;
    logic                    clk, resetn, cfg_load, store_cmd, recall_cmd;
    logic                    nv_wr_q, smux_q, wc_out_q;
    logic [2:0]              en, skip, line;
    logic [15:0]             half_ns [3];
    logic [15:0]             per_q;
    logic [5:0]              lock_q;
    logic [19:0]             rate_q;
    logic [31:0]             lfsr;
    ssr_pkg::ssr_cfg_t       cfg_in, nv_rdata, nv_wdata_q, cfg_q, c;
    ssr_pkg::ssr_clk_state_t cs_q;
    ssr_pkg::ssr_ref_t       ref_q;
    int                      fails, cmp_count, cycles;

    ssr_top dut (.clk(clk), .resetn(resetn), .wc_in(line[0]), .opt_in(line[1]),
        .spdif_in(line[2]), .cfg_in(cfg_in), .cfg_load(cfg_load), .store_cmd(store_cmd),
        .recall_cmd(recall_cmd), .nv_rdata(nv_rdata), .nv_wr_q(nv_wr_q),
        .nv_wdata_q(nv_wdata_q), .cfg_q(cfg_q), .clock_state_q(cs_q),
        .active_reference_report_q(ref_q), .ref_period_q(per_q),
        .per_input_lock_state_q(lock_q), .sample_multiplex_mode_q(smux_q),
        .sys_rate_hz_q(rate_q), .wc_out_q(wc_out_q));

    for (genvar g = 0; g < 3; g++) begin : g_src
        ssr_ref_src src (.en(en[g]), .half_ns(half_ns[g]), .skip(skip[g]), .line(line[g]));
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            $display("ERROR %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t %s: saw %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // One-cycle command pulse, ends 1 ns after the edge that took it
    task automatic cmd(input ssr_pkg::ssr_cfg_t v, input logic l, input logic s, input logic r);
        cyc(1);
        cfg_in = v;
        cfg_load = l;
        store_cmd = s;
        recall_cmd = r;
        cyc(1);
        cfg_load = 1'b0;
        store_cmd = 1'b0;
        recall_cmd = 1'b0;
    endtask : cmd

    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_step

    // Random settings kept to legal multipliers and rates
    function automatic ssr_pkg::ssr_cfg_t rnd();
        ssr_pkg::ssr_cfg_t v;
        lfsr = lfsr_step(lfsr);
        v[31:0] = lfsr;
        lfsr = lfsr_step(lfsr);
        v[47:32] = lfsr[15:0];
        v.auto_mode = 1'b0;
        v.mult = 2'(lfsr[17:16] % 3);
        v.base_hz = 18'h06d60 + 18'(lfsr[31:18]);
        return v;
    endfunction : rnd

    function automatic int synth(input ssr_pkg::ssr_cfg_t v);
        int r;
        r = int'(v.base_hz) << v.mult;
        if (v.coarse_act) r += int'(v.coarse_hz);
        if (v.fine_act) r += int'(v.fine_hz);
        return r;
    endfunction : synth

    function automatic ssr_pkg::ssr_ref_t exp_ref(input logic [2:0] ok);
        if (!c.auto_mode || ok == 3'h0) return ssr_pkg::REF_NONE;
        if (c.pref != ssr_pkg::REF_NONE && ok[c.pref]) return c.pref;
        for (int i = 0; i < 3; i++) if (ok[i]) return ssr_pkg::ssr_ref_t'(2'(i));
        return ssr_pkg::REF_NONE;
    endfunction : exp_ref

    // Wait for the predicted reference, let sync settle, compare reference, clock state, lock states, period and rate
    task automatic settle(input logic [2:0] ok);
        ssr_pkg::ssr_ref_t e;
        int                n;
        e = exp_ref(ok);
        n = 0;
        while (ref_q !== e && n < 12000) begin
            @(posedge clk);
            n++;
        end
        cyc(2500);
        check(ref_q, e, "reference");
        check(cs_q, e == ssr_pkg::REF_NONE ? ssr_pkg::CS_MASTER : ssr_pkg::CS_SLAVE, "state");
        for (int i = 0; i < 3; i++)
            check(lock_q[2*i+:2], !ok[i] ? 2'h0 : (i == e ? 2'h2 : 2'h1), "lock");
        if (e != ssr_pkg::REF_NONE)
            check(per_q inside {[half_ns[e] / 5 - 2 : half_ns[e] / 5 + 2]}, 1'b1, "period");
        check(rate_q, e == ssr_pkg::REF_NONE ? 20'(synth(c)) : 20'hbb80, "rate");
    endtask : settle

    initial begin
        longint t0;
        int     n;
        lfsr = 32'h74b1;
        {resetn, cfg_load, store_cmd, recall_cmd, en, skip} = '0;
        cfg_in = '0;
        half_ns = '{16'h0a5a, 16'h0bb8, 16'h0d48};
        nv_rdata = rnd();
        cyc(12);
        check(ref_q, ssr_pkg::REF_NONE, "reset ref");
        check(rate_q, 20'hbb80, "reset rate");
        resetn = 1'b1;
        cyc(2);
        check(cfg_q, nv_rdata, "boot load");
        c = rnd();
        cmd(c, 1'b1, 1'b0, 1'b0);
        cmd(c, 1'b0, 1'b1, 1'b0);
        check({nv_wr_q, nv_wdata_q}, {1'b1, c}, "store");
        cyc(1);
        check(nv_wr_q, 1'b0, "strobe width");
        nv_rdata = rnd();
        cmd(rnd(), 1'b1, 1'b0, 1'b1);
        check(cfg_q, nv_rdata, "recall wins");
        $display("settings store test done");
        for (int k = 0; k < 13; k++) begin
            c = rnd();
            c.synth_en = (k != 12);
            c.mult = 2'(k % 3);
            {c.fine_act, c.coarse_act} = 2'(k / 3);
            cmd(c, 1'b1, 1'b0, 1'b0);
            cyc(3);
            check(rate_q, c.synth_en ? 20'(synth(c)) : 20'hbb80, "synth");
        end
        $display("synth test done");
        c = '0;
        c.synth_en = 1'b1;
        c.base_hz = 18'h2ee00;
        for (int s = 0; s < 2; s++) begin
            c.single_speed = s[0];
            cmd(c, 1'b1, 1'b0, 1'b0);
            cyc(3000);
            @(posedge wc_out_q);
            t0 = $time;
            @(posedge wc_out_q);
            t0 = $time - t0 - (s ? 20833 : 5208);
            check(t0 inside {[-30:30]}, 1'b1, "word clock out");
        end
        $display("word clock out test done");
        c.auto_mode = 1'b1;
        c.base_hz = 18'h0ac44;
        c.pref = ssr_pkg::REF_WC;
        cmd(c, 1'b1, 1'b0, 1'b0);
        settle(3'h0);
        en = 3'h6;
        settle(3'h6);
        en = 3'h7;
        settle(3'h7);
        c.pref = ssr_pkg::REF_SPDIF;
        cmd(c, 1'b1, 1'b0, 1'b0);
        settle(3'h7);
        half_ns[2] = 16'h0050;
        settle(3'h3);
        n = 0;
        fork
            begin
                @(posedge line[0]);
                #10 skip[0] = 1'b1;
                #(3 * half_ns[0]) skip[0] = 1'b0;
            end
            repeat (3000) begin
                @(posedge clk);
                if (ref_q !== ssr_pkg::REF_WC) n++;
            end
        join
        check(n, 0, "glitch held");
        en = 3'h0;
        settle(3'h0);
        $display("reference selection test done");
        c.pref = ssr_pkg::REF_OPT;
        cmd(c, 1'b1, 1'b0, 1'b0);
        half_ns[1] = 16'h145a;
        en = 3'h2;
        settle(3'h2);
        check(smux_q, 1'b1, "multiplex on");
        @(posedge wc_out_q);
        t0 = $time;
        @(posedge wc_out_q);
        check(($time - t0) inside {[20830:20850]}, 1'b1, "clamped word clock");
        c.pref = ssr_pkg::REF_WC;
        cmd(c, 1'b1, 1'b0, 1'b0);
        cyc(3);
        check(smux_q, 1'b0, "multiplex off");
        $display("multiplex test done");
        end_of_test();
    end
endmodule : ssr_top_test

bind ssr_top ssr_top_sva u_sva (.clk(clk), .resetn(resetn), .cfg_in(cfg_in),
    .cfg_load(cfg_load), .store_cmd(store_cmd), .recall_cmd(recall_cmd), .nv_rdata(nv_rdata),
    .nv_wr_q(nv_wr_q), .nv_wdata_q(nv_wdata_q), .cfg_q(cfg_q), .clock_state_q(clock_state_q),
    .active_reference_report_q(active_reference_report_q),
    .per_input_lock_state_q(per_input_lock_state_q),
    .sample_multiplex_mode_q(sample_multiplex_mode_q), .sys_rate_hz_q(sys_rate_hz_q));
